//--- design/csr_pkg.sv
/*
 Constants and carrier types for the core status and interrupt
 register group. Assumes one 9-bit file address per access.
*/
package csr_pkg;
   // ------------------------------------------------------------
   // Register offsets (bank 0 / bank 1 form)
   // ------------------------------------------------------------
   localparam logic [8:0] STATUS_OFS = 9'h003;
   localparam logic [8:0] ICTL_OFS   = 9'h00b;
   localparam logic [8:0] PIR_OFS    = 9'h00c;
   localparam logic [8:0] OPTION_OFS = 9'h081;
   localparam logic [8:0] PIE_OFS    = 9'h08c;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int ST_IND_PG   = 7;
   localparam int ST_RP_HI    = 6;
   localparam int ST_RP_LO    = 5;
   localparam int ST_TO       = 4;
   localparam int ST_SLEEP    = 3;
   localparam int ST_Z        = 2;
   localparam int ST_DC       = 1;
   localparam int ST_C        = 0;
   localparam int OPT_PU_DIS  = 7;
   localparam int OPT_EXT_EDG = 6;
   localparam int OPT_T0_SRC  = 5;
   localparam int OPT_T0_EDG  = 4;
   localparam int OPT_PS_OWN  = 3;
   localparam int OPT_RATE_HI = 2;
   localparam int IC_GLB_EN   = 7;
   localparam int IC_PER_EN   = 6;
   localparam int IC_T0_EN    = 5;
   localparam int IC_EXT_EN   = 4;
   localparam int IC_CHG_EN   = 3;
   localparam int IC_T0_FLG   = 2;
   localparam int IC_EXT_FLG  = 1;
   localparam int IC_CHG_FLG  = 0;
   // ------------------------------------------------------------
   // Reset values and write masks
   // ------------------------------------------------------------
   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [7:0] OPTION_RST = 8'hff;
   localparam logic [7:0] ICTL_RST   = 8'h00;
   localparam logic [7:0] PIE_RST    = 8'h00;
   localparam logic [7:0] PIR_RST    = 8'h00;
   localparam logic [7:0] PIE_WMASK  = 8'hf7;
   localparam logic [7:0] PIR_WMASK  = 8'hc7;
   localparam logic [3:0] T0_DIV_MIN = 4'h1;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ALU_NONE  = 3'h0,
      ALU_ADD   = 3'h1,
      ALU_SUB   = 3'h2,
      ALU_LOGIC = 3'h3,
      ALU_ROR   = 3'h4,
      ALU_ROL   = 3'h5
   } csr_alu_op_t;
   typedef enum logic [2:0] {
      SEL_NONE   = 3'h0,
      SEL_STATUS = 3'h1,
      SEL_ICTL   = 3'h2,
      SEL_OPTION = 3'h3,
      SEL_PIE    = 3'h4,
      SEL_PIR    = 3'h5
   } csr_sel_t;
   typedef struct packed {
      csr_alu_op_t op;
      logic [7:0]  a;
      logic [7:0]  b;
      logic [7:0]  result;
   } csr_alu_req_t;
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] option;
      logic [7:0] interrupt_control;
      logic [7:0] pie;
      logic [7:0] pir;
      logic [7:0] rd_data;
      logic [1:0] ext_sync;
      logic       ext_last;
      logic [3:0] rb_sync0;
      logic [3:0] rb_sync1;
      logic [3:0] rb_last;
      logic [1:0] tck_sync;
      logic       tck_last;
      logic       irq;
      logic       t0_tick;
      logic [7:0] pullup_en;
      logic [3:0] t0_div_log2;
      logic [2:0] wdt_div_log2;
   } csr_state_t;
endpackage : csr_pkg

//--- design/csr_regs.sv
/*
 Core status, option, interrupt control and peripheral interrupt
 registers. Assumes the core presents one operand access and one
 ALU flag request per clock, all on sys_clk_i.
*/
// Summary of operation
// - Flag-updating op blocks status flag writes
// - Status bit 7 picks indirect upper banks
// - Status bits 6-5 pick direct bank
// - Timeout flag: one at start, zero on expiry
// - Sleep flag: one at start, zero on sleep
// - Zero flag follows result equal zero
// - Nibble carry, inverted as borrow on subtract
// - Carry from top bit, inverted borrow
// - Rotates load carry with bit shifted out
// - Option bit 7 disables all pull-ups
// - Option bit 6 picks external edge
// - Option bits 5-4 pick timer0 source, edge
// - Option bit 3 gives prescaler to watchdog
// - Rate field picks doubling divide ratios
// - Flags set regardless of any enable
// - Global enable gates every interrupt
// - Peripheral enable gates peripheral interrupts
// - Timer0 overflow flag sticky, masked by bit 5
// - External edge flag sticky, masked by bit 4
// - Port change flag sticky, masked by bit 3
// - Peripheral enables, bit 3 reads zero
// - Peripheral flags mirror enables, always set
`timescale 1ns/100ps
module csr_regs (
   // Clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  resetn_i,
   // Register operand access
   input  wire logic [8:0]            addr_i,
   input  wire logic                  wr_en_i,
   input  wire logic [7:0]            wr_data_i,
   input  wire logic                  rd_en_i,
   output logic      [7:0]            rd_data_o,
   // ALU flag request
   input  wire csr_pkg::csr_alu_req_t alu_i,
   // Core events
   input  wire logic                  wdt_clear_i,
   input  wire logic                  sleep_i,
   input  wire logic                  wdt_timeout_i,
   input  wire logic                  timer0_ovf_i,
   input  wire logic [7:0]            periph_evt_i,
   input  wire logic [7:0]            port_latch_i,
   // Pins
   input  wire logic                  ext_irq_pin_i,
   input  wire logic [3:0]            port_b_hi_i,
   input  wire logic                  timer_clk_pin_i,
   // Status and configuration
   output logic [7:0]                 status_o,
   output logic                       indirect_page_o,
   output logic [1:0]                 direct_bank_o,
   output logic [7:0]                 option_o,
   output logic [7:0]                 pullup_en_o,
   output logic                       timer0_tick_o,
   output logic                       prescaler_owner_o,
   output logic [3:0]                 t0_div_log2_o,
   output logic [2:0]                 wdt_div_log2_o,
   // Interrupt request
   output logic                       irq_o
);

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // Status and interrupt control mirror in all four banks,
   // option in banks 1 and 3.
   function automatic csr_pkg::csr_sel_t reg_sel(
      input logic [8:0] a
   );
      if (a[6:0] == csr_pkg::STATUS_OFS[6:0]) begin
         return csr_pkg::SEL_STATUS;
      end
      if (a[6:0] == csr_pkg::ICTL_OFS[6:0]) begin
         return csr_pkg::SEL_ICTL;
      end
      if (a[7:0] == csr_pkg::OPTION_OFS[7:0]) begin
         return csr_pkg::SEL_OPTION;
      end
      if (a == csr_pkg::PIE_OFS) begin
         return csr_pkg::SEL_PIE;
      end
      if (a == csr_pkg::PIR_OFS) begin
         return csr_pkg::SEL_PIR;
      end
      return csr_pkg::SEL_NONE;
   endfunction : reg_sel

   csr_pkg::csr_state_t s_r;
   csr_pkg::csr_state_t s_nxt;

   csr_pkg::csr_sel_t   sel;
   logic [7:0]          b_eff;
   logic                cin;
   logic [8:0]          sum9;
   logic [4:0]          nib5;
   logic                ext_edge;
   logic                rb_change;
   logic                tck_edge;
   logic                core_pend;
   logic                peri_pend;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      sel   = reg_sel(addr_i);

      // Pin synchronisers; edge logic looks only at stage two
      s_nxt.ext_sync = {s_r.ext_sync[0], ext_irq_pin_i};
      s_nxt.ext_last = s_r.ext_sync[1];
      s_nxt.rb_sync0 = port_b_hi_i;
      s_nxt.rb_sync1 = s_r.rb_sync0;
      s_nxt.rb_last  = s_r.rb_sync1;
      s_nxt.tck_sync = {s_r.tck_sync[0], timer_clk_pin_i};
      s_nxt.tck_last = s_r.tck_sync[1];

      if (s_r.option[csr_pkg::OPT_EXT_EDG]) begin
         ext_edge = s_r.ext_sync[1] & ~s_r.ext_last;
      end else begin
         ext_edge = ~s_r.ext_sync[1] & s_r.ext_last;
      end
      // Any change on the upper four pins counts; there is no edge choice
      rb_change = |(s_r.rb_sync1 ^ s_r.rb_last);

      // Subtract adds the two's complement of the second operand
      if (alu_i.op == csr_pkg::ALU_SUB) begin
         b_eff = ~alu_i.b;
         cin   = 1'b1;
      end else begin
         b_eff = alu_i.b;
         cin   = 1'b0;
      end
      // Nine bits keep the carry out of the top bit
      sum9 = {1'b0, alu_i.a} + {1'b0, b_eff} + {8'h00, cin};
      nib5 = {1'b0, alu_i.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};

      // ----------------------------------------------------------
      // Status register
      // ----------------------------------------------------------
      if (wr_en_i && sel == csr_pkg::SEL_STATUS) begin
         s_nxt.status[7:5] = wr_data_i[7:5];
         if (alu_i.op == csr_pkg::ALU_NONE) begin
            s_nxt.status[2:0] = wr_data_i[2:0];
         end
      end
      case (alu_i.op)
         csr_pkg::ALU_ADD,
         csr_pkg::ALU_SUB: begin
            s_nxt.status[csr_pkg::ST_Z]  = (sum9[7:0] == 8'h00);
            s_nxt.status[csr_pkg::ST_DC] = nib5[4];
            s_nxt.status[csr_pkg::ST_C]  = sum9[8];
         end
         csr_pkg::ALU_LOGIC: begin
            s_nxt.status[csr_pkg::ST_Z] = (alu_i.result == 8'h00);
         end
         csr_pkg::ALU_ROR: begin
            s_nxt.status[csr_pkg::ST_C] = alu_i.a[0];
         end
         csr_pkg::ALU_ROL: begin
            s_nxt.status[csr_pkg::ST_C] = alu_i.a[7];
         end
         default: begin
         end
      endcase
      // Timeout and sleep flags never take a write
      if (wdt_clear_i) begin
         s_nxt.status[csr_pkg::ST_TO] = 1'b1;
         s_nxt.status[csr_pkg::ST_SLEEP] = 1'b1;
      end
      if (sleep_i) begin
         s_nxt.status[csr_pkg::ST_TO] = 1'b1;
         s_nxt.status[csr_pkg::ST_SLEEP] = 1'b0;
      end
      // Expiry is the last word: it must survive a same-cycle clear
      if (wdt_timeout_i) begin
         s_nxt.status[csr_pkg::ST_TO] = 1'b0;
      end

      // ----------------------------------------------------------
      // Option register
      // ----------------------------------------------------------
      if (wr_en_i && sel == csr_pkg::SEL_OPTION) begin
         s_nxt.option = wr_data_i;
      end

      // ----------------------------------------------------------
      // Interrupt control and peripheral registers
      // ----------------------------------------------------------
      if (wr_en_i && sel == csr_pkg::SEL_ICTL) begin
         s_nxt.interrupt_control = wr_data_i;
      end
      // Hardware set after the write, so a set beats a clear
      if (timer0_ovf_i) begin
         s_nxt.interrupt_control[csr_pkg::IC_T0_FLG] = 1'b1;
      end
      if (ext_edge) begin
         s_nxt.interrupt_control[csr_pkg::IC_EXT_FLG] = 1'b1;
      end
      if (rb_change) begin
         s_nxt.interrupt_control[csr_pkg::IC_CHG_FLG] = 1'b1;
      end
      if (wr_en_i && sel == csr_pkg::SEL_PIE) begin
         s_nxt.pie = wr_data_i & csr_pkg::PIE_WMASK;
      end
      // Receive and transmit flags follow their peripherals, so
      // software can neither set nor clear them here
      if (wr_en_i && sel == csr_pkg::SEL_PIR) begin
         s_nxt.pir = (s_r.pir & ~csr_pkg::PIR_WMASK)
                   | (wr_data_i & csr_pkg::PIR_WMASK);
      end
      s_nxt.pir = s_nxt.pir | (periph_evt_i & csr_pkg::PIE_WMASK);

      // ----------------------------------------------------------
      // Interrupt request
      // ----------------------------------------------------------
      // Registered request: one cycle behind the flags, but free of
      // glitches from the enable and flag decode
      core_pend = (s_r.interrupt_control[csr_pkg::IC_T0_EN] & s_r.interrupt_control[csr_pkg::IC_T0_FLG])
                | (s_r.interrupt_control[csr_pkg::IC_EXT_EN] & s_r.interrupt_control[csr_pkg::IC_EXT_FLG])
                | (s_r.interrupt_control[csr_pkg::IC_CHG_EN] & s_r.interrupt_control[csr_pkg::IC_CHG_FLG]);
      peri_pend = s_r.interrupt_control[csr_pkg::IC_PER_EN] & (|(s_r.pie & s_r.pir));
      s_nxt.irq = s_r.interrupt_control[csr_pkg::IC_GLB_EN] & (core_pend | peri_pend);

      // ----------------------------------------------------------
      // Read port
      // ----------------------------------------------------------
      if (rd_en_i) begin
         case (sel)
            csr_pkg::SEL_STATUS: s_nxt.rd_data = s_r.status;
            csr_pkg::SEL_ICTL:   s_nxt.rd_data = s_r.interrupt_control;
            csr_pkg::SEL_OPTION: s_nxt.rd_data = s_r.option;
            csr_pkg::SEL_PIE:    s_nxt.rd_data = s_r.pie;
            csr_pkg::SEL_PIR:    s_nxt.rd_data = s_r.pir;
            default:             s_nxt.rd_data = 8'h00;
         endcase
      end

      // ----------------------------------------------------------
      // Option-driven outputs
      // ----------------------------------------------------------
      // Pull-up enables lag the latch by one cycle; weak pull-ups
      // are slow enough that this never shows on the pins
      if (s_r.option[csr_pkg::OPT_PU_DIS]) begin
         s_nxt.pullup_en = 8'h00;
      end else begin
         s_nxt.pullup_en = port_latch_i;
      end
      if (s_r.option[csr_pkg::OPT_T0_EDG]) begin
         tck_edge = ~s_r.tck_sync[1] & s_r.tck_last;
      end else begin
         tck_edge = s_r.tck_sync[1] & ~s_r.tck_last;
      end
      // Internal source ticks once per instruction clock
      if (s_r.option[csr_pkg::OPT_T0_SRC]) begin
         s_nxt.t0_tick = tck_edge;
      end else begin
         s_nxt.t0_tick = 1'b1;
      end
      // Timer0 divides by two at the lowest rate, the watchdog by one
      s_nxt.t0_div_log2  = {1'b0, s_r.option[csr_pkg::OPT_RATE_HI:0]}
                         + csr_pkg::T0_DIV_MIN;
      s_nxt.wdt_div_log2 = s_r.option[csr_pkg::OPT_RATE_HI:0];
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         s_r              <= '0;
         s_r.status       <= csr_pkg::STATUS_RST;
         s_r.option       <= csr_pkg::OPTION_RST;
         s_r.interrupt_control       <= csr_pkg::ICTL_RST;
         s_r.pie          <= csr_pkg::PIE_RST;
         s_r.pir          <= csr_pkg::PIR_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs, each straight from the state register
   // ------------------------------------------------------------
   assign rd_data_o         = s_r.rd_data;
   assign status_o          = s_r.status;
   assign indirect_page_o   = s_r.status[csr_pkg::ST_IND_PG];
   assign direct_bank_o     = s_r.status[csr_pkg::ST_RP_HI:csr_pkg::ST_RP_LO];
   assign option_o          = s_r.option;
   assign pullup_en_o       = s_r.pullup_en;
   assign timer0_tick_o     = s_r.t0_tick;
   assign prescaler_owner_o = s_r.option[csr_pkg::OPT_PS_OWN];
   assign t0_div_log2_o     = s_r.t0_div_log2;
   assign wdt_div_log2_o    = s_r.wdt_div_log2;
   assign irq_o             = s_r.irq;

endmodule : csr_regs

//--- verif/csr_regs_assertions.sv
/*
 Concurrent checks on the ports of csr_regs.
 Assumes one clock domain and the bind in the bench top file.
*/
`timescale 1ns/100ps
module csr_regs_assertions (
   // Watched ports
   input wire logic                  sys_clk_i,
   input wire logic                  resetn_i,
   input wire logic [8:0]            addr_i,
   input wire logic                  wr_en_i,
   input wire logic [7:0]            wr_data_i,
   input wire logic                  rd_en_i,
   input wire logic [7:0]            rd_data_o,
   input wire csr_pkg::csr_alu_req_t alu_i,
   input wire logic                  wdt_clear_i,
   input wire logic                  sleep_i,
   input wire logic                  wdt_timeout_i,
   input wire logic [7:0]            status_o,
   input wire logic                  indirect_page_o,
   input wire logic [1:0]            direct_bank_o,
   input wire logic [7:0]            option_o,
   input wire logic [7:0]            pullup_en_o,
   input wire logic                  prescaler_owner_o,
   input wire logic [3:0]            t0_div_log2_o,
   input wire logic [2:0]            wdt_div_log2_o
);
   // Expected add carries, worked out apart from the design's adder
   logic [4:0] add_nib;
   logic [8:0] add_sum;
   assign add_nib = {1'b0, alu_i.a[3:0]} + {1'b0, alu_i.b[3:0]};
   assign add_sum = {1'b0, alu_i.a} + {1'b0, alu_i.b};
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   AST_UNMAPPED_RD: assert property (rd_en_i && addr_i == 9'h004 |=> rd_data_o == 8'h00)
      else $error("unmapped read not zero");
   AST_TO_EXPIRE: assert property (wdt_timeout_i |=> !status_o[4])
      else $error("timeout flag not cleared");
   AST_SLEEP: assert property (sleep_i && !wdt_timeout_i && !wdt_clear_i |=> status_o[4:3] == 2'b10)
      else $error("sleep flags wrong");
   AST_CLEAR: assert property (wdt_clear_i && !sleep_i && !wdt_timeout_i |=> status_o[4:3] == 2'b11)
      else $error("watchdog clear flags wrong");
   AST_RO_BITS: assert property (wr_en_i && addr_i[6:0] == 7'h03 && !wdt_clear_i && !sleep_i && !wdt_timeout_i
      |=> $stable(status_o[4:3]))
      else $error("read-only status bits written");
   AST_ZERO: assert property (alu_i.op == csr_pkg::ALU_LOGIC |=> status_o[2] == ($past(alu_i.result) == 8'h00))
      else $error("zero flag wrong");
   AST_ADD: assert property (alu_i.op == csr_pkg::ALU_ADD
      |=> status_o[1:0] == {$past(add_nib[4]), $past(add_sum[8])})
      else $error("add carries wrong");
   AST_ROR: assert property (alu_i.op == csr_pkg::ALU_ROR |=> status_o[0] == $past(alu_i.a[0]))
      else $error("rotate carry wrong");
   AST_BANK: assert property (wr_en_i && addr_i[6:0] == 7'h03
      |=> {indirect_page_o, direct_bank_o} == $past(wr_data_i[7:5]))
      else $error("bank selects differ from status");
   AST_PULLUP: assert property (option_o[7] |=> pullup_en_o == 8'h00)
      else $error("pull-ups on while disabled");
   AST_OWNER: assert property (wr_en_i && addr_i[7:0] == 8'h81 |=> prescaler_owner_o == $past(wr_data_i[3]))
      else $error("prescaler owner wrong");
   AST_DIV: assert property ($past(resetn_i) |-> t0_div_log2_o == {1'b0, $past(option_o[2:0])} + 4'h1
      && wdt_div_log2_o == $past(option_o[2:0]))
      else $error("divide ratios wrong");
endmodule : csr_regs_assertions

//--- verif/csr_core_model.sv
/*
 Behavioural model of the processor core: operand reads, writes
 and ALU flag requests. Assumes requests launch 1 ns after an edge.
*/
`timescale 1ns/100ps
module csr_core_model (
   // Clock
   input  wire logic             sys_clk_i,
   // Operand access
   output logic [8:0]            addr_o,
   output logic                  wr_en_o,
   output logic [7:0]            wr_data_o,
   output logic                  rd_en_o,
   input  wire logic [7:0]       rd_data_i,
   output csr_pkg::csr_alu_req_t alu_o
);
   // Released lines show inverted values, the ALU op returns to ALU_NONE, so stale data is never trusted
   initial begin
      addr_o = 9'h000;
      {wr_en_o, rd_en_o} = 2'b00;
      wr_data_o = 8'h00;
      alu_o = '0;
   end
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      #1;
      {addr_o, wr_data_o, wr_en_o} = {a, d, 1'b1};
      @(posedge sys_clk_i);
      #1;
      {addr_o, wr_data_o, wr_en_o} = {~a, ~d, 1'b0};
   endtask : wr
   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      #1;
      {addr_o, rd_en_o} = {a, 1'b1};
      @(posedge sys_clk_i);
      #1;
      d = rd_data_i;
      {addr_o, rd_en_o} = {~a, 1'b0};
   endtask : rd
   task automatic alu(input csr_pkg::csr_alu_op_t op, input logic [7:0] a, b, r);
      @(posedge sys_clk_i);
      #1;
      alu_o = '{op, a, b, r};
      @(posedge sys_clk_i);
      #1;
      alu_o = '{csr_pkg::ALU_NONE, ~a, ~b, ~r};
   endtask : alu
endmodule : csr_core_model

//--- verif/csr_regs_bench.sv
/*
 Self-checking bench for csr_regs. Assumes csr_core_model drives
 the operand and ALU ports; events and pins are driven here.
*/
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module csr_regs_bench;
   logic                  sys_clk_i, resetn_i, wr_en_i, rd_en_i, wdt_clear_i, sleep_i, wdt_timeout_i;
   logic                  timer0_ovf_i, ext_irq_pin_i, timer_clk_pin_i, indirect_page_o, timer0_tick_o;
   logic                  prescaler_owner_o, irq_o;
   logic [8:0]            addr_i;
   logic [7:0]            wr_data_i, rd_data_o, periph_evt_i, port_latch_i, status_o, option_o, pullup_en_o;
   logic [7:0]            rv, a, b, r;
   logic [3:0]            port_b_hi_i, t0_div_log2_o;
   logic [2:0]            wdt_div_log2_o, fl;
   logic [1:0]            direct_bank_o;
   csr_pkg::csr_alu_req_t alu_i;
   csr_pkg::csr_alu_op_t  op;
   int                    mismatches, n_checks;
   logic [8:0]            ra [6] = '{9'h003, 9'h081, 9'h00b, 9'h08c, 9'h00c, 9'h004};
   logic [7:0]            rx [6] = '{8'h18, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [2:0]            ev [5] = '{3'b010, 3'b001, 3'b100, 3'b010, 3'b101};
   logic [1:0]            ex [5] = '{2'b10, 2'b11, 2'b01, 2'b10, 2'b01};
   csr_regs i_csr_regs (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
      .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .alu_i(alu_i), .wdt_clear_i(wdt_clear_i),
      .sleep_i(sleep_i), .wdt_timeout_i(wdt_timeout_i), .timer0_ovf_i(timer0_ovf_i), .periph_evt_i(periph_evt_i),
      .port_latch_i(port_latch_i), .ext_irq_pin_i(ext_irq_pin_i), .port_b_hi_i(port_b_hi_i),
      .timer_clk_pin_i(timer_clk_pin_i), .status_o(status_o), .indirect_page_o(indirect_page_o),
      .direct_bank_o(direct_bank_o), .option_o(option_o), .pullup_en_o(pullup_en_o), .timer0_tick_o(timer0_tick_o),
      .prescaler_owner_o(prescaler_owner_o), .t0_div_log2_o(t0_div_log2_o), .wdt_div_log2_o(wdt_div_log2_o),
      .irq_o(irq_o));
   csr_core_model i_csr_core_model (.sys_clk_i(sys_clk_i), .addr_o(addr_i), .wr_en_o(wr_en_i),
      .wr_data_o(wr_data_i), .rd_en_o(rd_en_i), .rd_data_i(rd_data_o), .alu_o(alu_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic [2:0] alu_flags(input csr_pkg::csr_alu_op_t op, input logic [7:0] a, b, r,
                                            input logic [2:0] f);
      logic [7:0] bb;
      logic [8:0] s;
      logic [4:0] n;
      bb = (op == csr_pkg::ALU_SUB) ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + {8'h00, op == csr_pkg::ALU_SUB};
      n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, op == csr_pkg::ALU_SUB};
      case (op)
         csr_pkg::ALU_ADD, csr_pkg::ALU_SUB: return {s[7:0] == 8'h00, n[4], s[8]};
         csr_pkg::ALU_LOGIC: return {r == 8'h00, f[1:0]};
         csr_pkg::ALU_ROR: return {f[2:1], a[0]};
         csr_pkg::ALU_ROL: return {f[2:1], a[7]};
         default: return f;
      endcase
   endfunction : alu_flags
   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : wait_n
   task automatic chk_rd(input logic [8:0] ad, input logic [7:0] e);
      logic [7:0] d;
      i_csr_core_model.rd(ad, d);
      `CHK("read", e, d)
   endtask : chk_rd
   // Moves the timer clock pin once and counts ticks over six cycles
   task automatic pin_ticks(input logic v, input logic [3:0] e);
      logic [3:0] c;
      c = 4'h0;
      timer_clk_pin_i = v;
      repeat (6) begin
         wait_n(1);
         c = c + {3'b000, timer0_tick_o};
      end
      `CHK("tick_ext", e, c)
   endtask : pin_ticks
   task automatic test_done();
      if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   // Run needs well under 1000 cycles; the span leaves ample margin
   initial begin
      #100000;
      mismatches++;
      test_done();
   end
   initial begin
      {wdt_clear_i, sleep_i, wdt_timeout_i, timer0_ovf_i, ext_irq_pin_i, timer_clk_pin_i} = 6'h00;
      {periph_evt_i, port_latch_i, port_b_hi_i} = 20'h00000;
      resetn_i = 1'b0;
      mismatches = 0;
      n_checks = 0;
      void'($urandom(32'h2027));
      repeat (20) @(posedge sys_clk_i);
      #1 resetn_i = 1'b1;
      i_csr_core_model.wr(9'h004, 8'h5a);
      for (int i = 0; i < 6; i++) chk_rd(ra[i], rx[i]);
      for (int i = 0; i < 8; i++) begin
         rv = {5'($urandom), i[2:0]};
         port_latch_i = 8'($urandom);
         i_csr_core_model.wr(i[0] ? 9'h181 : csr_pkg::OPTION_OFS, rv);
         wait_n(1);
         `CHK("pullup", rv[7] ? 8'h00 : port_latch_i, pullup_en_o)
         `CHK("owner", rv[3], prescaler_owner_o)
         `CHK("divs", {({1'b0, rv[2:0]} + 4'h1), rv[2:0]}, {t0_div_log2_o, wdt_div_log2_o})
         if (!rv[5]) `CHK("tick", 1'b1, timer0_tick_o)
         chk_rd(csr_pkg::OPTION_OFS, rv);
      end
      i_csr_core_model.wr(csr_pkg::OPTION_OFS, 8'h28);
      pin_ticks(1'b1, 4'h1);
      pin_ticks(1'b0, 4'h0);
      i_csr_core_model.wr(csr_pkg::OPTION_OFS, 8'h38);
      pin_ticks(1'b1, 4'h0);
      pin_ticks(1'b0, 4'h1);
      i_csr_core_model.wr(csr_pkg::OPTION_OFS, 8'h48);
      for (int i = 0; i < 6; i++) begin
         rv = 8'($urandom);
         i_csr_core_model.wr({rv[4:3], 7'h03}, rv);
         `CHK("bank", rv[7:5], {indirect_page_o, direct_bank_o})
         chk_rd(csr_pkg::STATUS_OFS, {rv[7:5], 2'b11, rv[2:0]});
      end
      fl = rv[2:0];
      for (int i = 0; i < 30; i++) begin
         op = csr_pkg::csr_alu_op_t'($urandom_range(5, 1));
         a = 8'($urandom);
         b = (i < 4) ? a : 8'($urandom);
         r = i[0] ? 8'h00 : 8'($urandom);
         if (i == 4) begin
            op = csr_pkg::ALU_ADD;
            a = 8'h0f;
            b = 8'h01;
         end
         fl = alu_flags(op, a, b, r, fl);
         if (i == 5) fork
            i_csr_core_model.wr(csr_pkg::STATUS_OFS, 8'h07);
            i_csr_core_model.alu(op, a, b, r);
         join
         else i_csr_core_model.alu(op, a, b, r);
         `CHK("flags", fl, status_o[2:0])
      end
      for (int i = 0; i < 5; i++) begin
         {wdt_timeout_i, sleep_i, wdt_clear_i} = ev[i];
         wait_n(1);
         `CHK("to_pd", ex[i], status_o[4:3])
      end
      {wdt_timeout_i, sleep_i, wdt_clear_i} = 3'b000;
      i_csr_core_model.wr(csr_pkg::ICTL_OFS, 8'h20);
      timer0_ovf_i = 1'b1;
      wait_n(1);
      timer0_ovf_i = 1'b0;
      wait_n(3);
      `CHK("irq_gie0", 1'b0, irq_o)
      chk_rd(9'h18b, 8'h24);
      i_csr_core_model.wr(csr_pkg::ICTL_OFS, 8'ha4);
      wait_n(2);
      `CHK("irq_t0", 1'b1, irq_o)
      i_csr_core_model.wr(csr_pkg::ICTL_OFS, 8'h90);
      ext_irq_pin_i = 1'b1;
      wait_n(6);
      `CHK("irq_ext", 1'b1, irq_o)
      i_csr_core_model.wr(csr_pkg::ICTL_OFS, 8'h88);
      ext_irq_pin_i = 1'b0;
      port_b_hi_i = 4'h8;
      wait_n(6);
      chk_rd(csr_pkg::ICTL_OFS, 8'h89);
      i_csr_core_model.wr(csr_pkg::ICTL_OFS, 8'h80);
      i_csr_core_model.wr(csr_pkg::PIE_OFS, 8'hff);
      chk_rd(csr_pkg::PIE_OFS, 8'hf7);
      periph_evt_i = 8'h01;
      wait_n(1);
      periph_evt_i = 8'h00;
      wait_n(2);
      `CHK("irq_peie0", 1'b0, irq_o)
      chk_rd(csr_pkg::PIR_OFS, 8'h01);
      i_csr_core_model.wr(csr_pkg::ICTL_OFS, 8'hc0);
      wait_n(2);
      `CHK("irq_peie1", 1'b1, irq_o)
      test_done();
   end
endmodule : csr_regs_bench
bind csr_regs csr_regs_assertions i_csr_regs_assertions (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
   .addr_i(addr_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .alu_i(alu_i),
   .wdt_clear_i(wdt_clear_i), .sleep_i(sleep_i), .wdt_timeout_i(wdt_timeout_i), .status_o(status_o),
   .indirect_page_o(indirect_page_o), .direct_bank_o(direct_bank_o), .option_o(option_o),
   .pullup_en_o(pullup_en_o), .prescaler_owner_o(prescaler_owner_o), .t0_div_log2_o(t0_div_log2_o),
   .wdt_div_log2_o(wdt_div_log2_o));
